// File: rtl/ptoc_defs.svh
/*
  Offsets, field positions, reset values and masks for the PWM trigger and
  output-pin conditioning block.
  Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
*/
`ifndef PTOC_DEFS_SVH
`define PTOC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PTOC_OFS_TRIGGER_CONTROL    4'h0
`define PTOC_OFS_OUTPUT_PIN_CONTROL 4'h4
`define PTOC_OFS_FAULT_CL_CONTROL   4'h8
`define PTOC_OFS_MODULE_CONTROL     4'hc

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTOC_TRG_DIV_LSB    12
`define PTOC_TRG_DUAL_BIT     7
`define PTOC_TRG_STRT_LSB     0
`define PTOC_IO_HIGH_POL_BIT  13
`define PTOC_IO_LOW_POL_BIT   12
`define PTOC_IO_OVREN_H_BIT   9
`define PTOC_IO_OVREN_L_BIT   8
`define PTOC_IO_OVR_DATA_LSB  6
`define PTOC_IO_CL_STATE_LSB  2
`define PTOC_IO_SWAP_BIT      1
`define PTOC_IO_OVR_SYNC_BIT  0
`define PTOC_FCL_IFLT_BIT     15
`define PTOC_FCL_CL_MODE_BIT  8
`define PTOC_MOD_EN_BIT     15

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define PTOC_TRG_RESET  16'h0000
`define PTOC_IO_RESET   16'h0000
`define PTOC_FCL_RESET  16'h0000
`define PTOC_MOD_RESET  16'h0000
`define PTOC_TRG_MASK   16'hf0bf
`define PTOC_IO_MASK    16'h33cf
`define PTOC_FCL_MASK   16'h8100
`define PTOC_MOD_MASK   16'h8000

`endif

// File: rtl/ptoc_pin_if.sv
/*
  Interface carrying pin-conditioning controls to the output stage.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none

interface ptoc_pin_if;
  logic       pwm_high;
  logic       pwm_low;
  logic       current_limit_active;
  logic       independent_fault_mode;
  logic [1:0] current_limit_pin_state;
  logic       swap;
  logic       high_side_polarity;
  logic       low_side_polarity;
  logic [1:0] override_enable;
  logic [1:0] override_pin_data;
  logic       next_high;
  logic       next_low;

  modport ctrl (
    output pwm_high, pwm_low, current_limit_active, independent_fault_mode,
    output current_limit_pin_state, swap, high_side_polarity,
    output low_side_polarity, override_enable, override_pin_data,
    input  next_high, next_low
  );
  modport stage (
    input  pwm_high, pwm_low, current_limit_active, independent_fault_mode,
    input  current_limit_pin_state, swap, high_side_polarity,
    input  low_side_polarity, override_enable, override_pin_data,
    output next_high, next_low
  );
endinterface : ptoc_pin_if

`default_nettype wire

// File: rtl/ptoc_pin_stage.sv
/*
  Combinational pin conditioning: current limit, override, swap, polarity.
  Assumes the caller registers the results.
*/
`timescale 1ns/1ns
`default_nettype none

module ptoc_pin_stage (
  ptoc_pin_if.stage pins
);

  logic active_high;
  logic active_low;

  always_comb begin
    active_high = pins.pwm_high;
    active_low  = pins.pwm_low;
    if (pins.current_limit_active && !pins.independent_fault_mode) begin
      active_high = pins.current_limit_pin_state[1];
      active_low  = pins.current_limit_pin_state[0];
    end
    if (pins.override_enable[1]) begin
      active_high = pins.override_pin_data[1];
    end
    if (pins.override_enable[0]) begin
      active_low = pins.override_pin_data[0];
    end
    if (pins.swap) begin
      pins.next_high = active_low ^ pins.high_side_polarity;
      pins.next_low  = active_high ^ pins.low_side_polarity;
    end else begin
      pins.next_high = active_high ^ pins.high_side_polarity;
      pins.next_low  = active_low ^ pins.low_side_polarity;
    end
  end

endmodule // ptoc_pin_stage

`default_nettype wire

// File: rtl/ptoc_pkg.sv
/*
  Types shared by the trigger and output-pin conditioning block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ptoc_pkg;

  typedef enum logic [1:0] {
    ptoc_idle,
    ptoc_delay,
    ptoc_run
  } ptoc_phase_type;

  typedef struct packed {
    logic [15:0]    trigger_control;
    logic [15:0]    output_pin_control;
    logic [15:0]    fault_current_limit_control;
    logic [15:0]    module_control;
    logic           waitrequest;
    logic [31:0]    readdata;
    ptoc_phase_type phase;
    logic [5:0]     delay_count;
    logic [3:0]     event_count;
    logic           trigger_out;
    logic           secondary_trigger_out;
    logic [1:0]     override_applied;
    logic [1:0]     override_enable_applied;
    logic           high_side_output;
    logic           low_side_output;
  } ptoc_state_type;

endpackage : ptoc_pkg

// File: rtl/ptoc_top.sv
/*
  PWM trigger postscaler, start delay and output-pin conditioning with an
  Avalon-MM register slave.
  Assumes pwm_cycle_start pulses once per PWM period and that trigger
  events arrive as one-cycle pulses on the same clock.
*/
// Our own choices: the placing of the registers and the Avalon-MM slave port.
// How it works
// - Output trigger every divider-plus-one events.
// - Dual mode merges secondary into primary trigger.
// - Wait start-delay PWM cycles before first trigger.
// - Normal mode: limit data bits drive pins.
// - Independent fault mode ignores limit data.
// - Swap routes high signal to low pin.
// - Overrides apply at PWM cycle or next clock.
// - Pin states pass through side polarity settings.
`timescale 1ns/1ns
`default_nettype none
`include "ptoc_defs.svh"

module ptoc_top
  import ptoc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        pwm_cycle_start,
  input  wire logic        primary_trigger_event,
  input  wire logic        secondary_trigger_event,
  input  wire logic        pwm_high_in,
  input  wire logic        pwm_low_in,
  input  wire logic        current_limit_active,
  output logic             trigger_out,
  output logic             secondary_trigger_out,
  output logic             high_side_output,
  output logic             low_side_output,
  output logic             pwm_module_enable
);

  ptoc_state_type state;
  ptoc_state_type next_state;
  ptoc_pin_if     pins ();

  logic [3:0] trigger_divider;
  logic       dual_trigger_mode;
  logic [5:0] trigger_start_delay;
  logic       override_sync;
  logic       enabled;
  logic       any_event;
  logic       slave_access;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  function automatic logic [15:0] reg_mask(input logic [3:0] addr);
    case (addr)
      `PTOC_OFS_TRIGGER_CONTROL:    reg_mask = `PTOC_TRG_MASK;
      `PTOC_OFS_OUTPUT_PIN_CONTROL: reg_mask = `PTOC_IO_MASK;
      `PTOC_OFS_FAULT_CL_CONTROL:   reg_mask = `PTOC_FCL_MASK;
      `PTOC_OFS_MODULE_CONTROL:     reg_mask = `PTOC_MOD_MASK;
      default:                      reg_mask = 16'h0000;
    endcase
  endfunction

  assign trigger_divider     = state.trigger_control[`PTOC_TRG_DIV_LSB+:4];
  assign dual_trigger_mode   = state.trigger_control[`PTOC_TRG_DUAL_BIT];
  assign trigger_start_delay = state.trigger_control[`PTOC_TRG_STRT_LSB+:6];
  assign override_sync       = state.output_pin_control[`PTOC_IO_OVR_SYNC_BIT];
  assign enabled             = state.module_control[`PTOC_MOD_EN_BIT];
  assign slave_access        = (avs_read || avs_write) && state.waitrequest;

  // ----------------------------------------------------------------------
  // Pin stage
  // ----------------------------------------------------------------------
  assign pins.pwm_high             = pwm_high_in;
  assign pins.pwm_low              = pwm_low_in;
  assign pins.current_limit_active = current_limit_active &&
    state.fault_current_limit_control[`PTOC_FCL_CL_MODE_BIT];
  assign pins.independent_fault_mode =
    state.fault_current_limit_control[`PTOC_FCL_IFLT_BIT];
  assign pins.current_limit_pin_state =
    state.output_pin_control[`PTOC_IO_CL_STATE_LSB+:2];
  assign pins.swap = state.output_pin_control[`PTOC_IO_SWAP_BIT];
  assign pins.high_side_polarity =
    state.output_pin_control[`PTOC_IO_HIGH_POL_BIT];
  assign pins.low_side_polarity =
    state.output_pin_control[`PTOC_IO_LOW_POL_BIT];
  assign pins.override_enable   = state.override_enable_applied;
  assign pins.override_pin_data = state.override_applied;

  ptoc_pin_stage u_pin_stage (
    .pins (pins.stage)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state                       = state;
    next_state.trigger_out           = 1'b0;
    next_state.secondary_trigger_out = 1'b0;
    next_state.readdata              = 32'h0000_0000;
    any_event = primary_trigger_event ||
                (dual_trigger_mode && secondary_trigger_event);

    // Every access takes one wait cycle; a write lands only at the edge
    // where the master sees waitrequest low, as the bus defines it.
    next_state.waitrequest = !slave_access;
    if (avs_write && !state.waitrequest) begin
      case (avs_address)
        `PTOC_OFS_TRIGGER_CONTROL:
          next_state.trigger_control = avs_writedata[15:0] & `PTOC_TRG_MASK;
        `PTOC_OFS_OUTPUT_PIN_CONTROL:
          next_state.output_pin_control = avs_writedata[15:0] & `PTOC_IO_MASK;
        `PTOC_OFS_FAULT_CL_CONTROL:
          next_state.fault_current_limit_control =
            avs_writedata[15:0] & `PTOC_FCL_MASK;
        `PTOC_OFS_MODULE_CONTROL:
          next_state.module_control = avs_writedata[15:0] & `PTOC_MOD_MASK;
        default: ;
      endcase
    end
    if (slave_access && avs_read) begin
      case (avs_address)
        `PTOC_OFS_TRIGGER_CONTROL:
          next_state.readdata = {16'h0000, state.trigger_control};
        `PTOC_OFS_OUTPUT_PIN_CONTROL:
          next_state.readdata = {16'h0000, state.output_pin_control};
        `PTOC_OFS_FAULT_CL_CONTROL:
          next_state.readdata = {16'h0000, state.fault_current_limit_control};
        `PTOC_OFS_MODULE_CONTROL:
          next_state.readdata = {11'h000, state.event_count,
            state.delay_count, 9'h000, state.phase} |
            {16'h0000, state.module_control & reg_mask(avs_address)};
        default: next_state.readdata = 32'h0000_0000;
      endcase
    end

    // Start delay and postscaler.
    case (state.phase)
      ptoc_idle: begin
        next_state.delay_count = 6'h00;
        next_state.event_count = 4'h0;
        if (enabled) begin
          next_state.phase = (trigger_start_delay == 6'h00) ?
            ptoc_run : ptoc_delay;
        end
      end
      ptoc_delay: begin
        if (pwm_cycle_start) begin
          next_state.delay_count = state.delay_count + 6'h01;
          if (state.delay_count + 6'h01 >= trigger_start_delay) begin
            next_state.phase = ptoc_run;
          end
        end
      end
      ptoc_run: begin
        if (any_event) begin
          if (state.event_count >= trigger_divider) begin
            next_state.event_count = 4'h0;
            next_state.trigger_out = 1'b1;
          end else begin
            next_state.event_count = state.event_count + 4'h1;
          end
        end
        // Separate secondary trigger only when not merged.
        next_state.secondary_trigger_out =
          secondary_trigger_event && !dual_trigger_mode;
      end
      default: next_state.phase = ptoc_idle;
    endcase
    if (!enabled) begin
      next_state.phase       = ptoc_idle;
      next_state.delay_count = 6'h00;
      next_state.event_count = 4'h0;
    end

    // Override capture: on PWM cycle start when synced, else next clock.
    if (!override_sync || pwm_cycle_start) begin
      next_state.override_applied =
        state.output_pin_control[`PTOC_IO_OVR_DATA_LSB+:2];
      next_state.override_enable_applied = {
        state.output_pin_control[`PTOC_IO_OVREN_H_BIT],
        state.output_pin_control[`PTOC_IO_OVREN_L_BIT]};
    end

    next_state.high_side_output = pins.next_high;
    next_state.low_side_output  = pins.next_low;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state                             <= '0;
      state.trigger_control             <= `PTOC_TRG_RESET;
      state.output_pin_control          <= `PTOC_IO_RESET;
      state.fault_current_limit_control <= `PTOC_FCL_RESET;
      state.module_control              <= `PTOC_MOD_RESET;
      state.waitrequest                 <= 1'b1;
      state.phase                       <= ptoc_idle;
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata          = state.readdata;
  assign avs_waitrequest       = state.waitrequest;
  assign trigger_out           = state.trigger_out;
  assign secondary_trigger_out = state.secondary_trigger_out;
  assign high_side_output      = state.high_side_output;
  assign low_side_output       = state.low_side_output;
  assign pwm_module_enable     = state.module_control[`PTOC_MOD_EN_BIT];

endmodule // ptoc_top

`default_nettype wire

// File: verif/ptoc_assertions.sv
/* Checker for the trigger and pin block.
   Assumes it is bound to ptoc_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module ptoc_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic pwm_cycle_start,
  input wire logic primary_trigger_event,
  input wire logic secondary_trigger_event,
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  input wire logic current_limit_active,
  input wire logic trigger_out,
  input wire logic secondary_trigger_out,
  input wire logic high_side_output,
  input wire logic low_side_output,
  input wire logic pwm_module_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence seq_quiet;
    ($stable(pwm_high_in) && $stable(pwm_low_in) && !avs_write &&
     $stable(current_limit_active) && !pwm_cycle_start) [*4];
  endsequence
  AST_ACK_ONE:
    assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ACK_NEXT:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered");
  AST_TRIG_CAUSE:
    assert property (trigger_out |-> $past(primary_trigger_event) ||
      $past(secondary_trigger_event)) else $error("trigger without event");
  AST_SEC_CAUSE:
    assert property (secondary_trigger_out |->
      $past(secondary_trigger_event)) else $error("stray secondary");
  AST_IDLE_QUIET:
    assert property (!pwm_module_enable && !$past(pwm_module_enable) |->
      !trigger_out && !secondary_trigger_out) else $error("idle trigger");
  AST_START_QUIET:
    assert property ($rose(pwm_module_enable) |-> !trigger_out &&
      !secondary_trigger_out) else $error("trigger at enable");
  AST_EN_BY_WRITE:
    assert property ($changed(pwm_module_enable) |-> $past(avs_write) ||
      $past(avs_write, 2)) else $error("enable changed without write");
  AST_PIN_SETTLE:
    assert property (seq_quiet |=> $stable(high_side_output) &&
      $stable(low_side_output)) else $error("pins moved while quiet");
endmodule // ptoc_assertions
`default_nettype wire

// File: verif/ptoc_gate_model.sv
/* Gate driver and current sense of the power stage.
   Assumes the bench commands a current trip. */
`timescale 1ns/1ns
`default_nettype none
module ptoc_gate_model (
  input  wire logic clock,
  input  wire logic high_side_output,
  input  wire logic low_side_output,
  input  wire logic trip,
  output logic      current_limit_active
);
  // The sense comparator lags one cycle, as a real one would.
  initial current_limit_active = 1'b0;
  always @(posedge clock) begin
    current_limit_active <= trip;
  end
endmodule // ptoc_gate_model
`default_nettype wire

// File: verif/tb_top.sv
/* Self-checking bench for the trigger and pin block.
   Assumes the design, its package and the checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "ptoc_defs.svh"
module tb_top;
  logic clock = 0, rst_n = 0, rd = 0, wr = 0, cs = 0, pe = 0, se = 0;
  logic hin = 0, lin = 0, trip = 0, probe = 0, cnt_clr = 1;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata, r;
  logic wreq, cla, trg, strg, hso, lso, pme;
  logic [7:0] tcnt, scnt;
  logic [15:0] mk [3] = '{`PTOC_TRG_MASK, `PTOC_IO_MASK, `PTOC_FCL_MASK};
  int errors = 0, checks_done = 0, seed = 23;
  logic [31:0] exp_q [$];
  int dv [3] = '{0, 3, 15};
  int dl [2] = '{1, 63};
  always #50 clock = ~clock;
  ptoc_top dut_u (.clock(clock), .rst_n(rst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .pwm_cycle_start(cs),
    .primary_trigger_event(pe), .secondary_trigger_event(se),
    .pwm_high_in(hin), .pwm_low_in(lin), .current_limit_active(cla),
    .trigger_out(trg), .secondary_trigger_out(strg),
    .high_side_output(hso), .low_side_output(lso), .pwm_module_enable(pme));
  ptoc_gate_model gate_u (.clock(clock), .high_side_output(hso),
    .low_side_output(lso), .trip(trip), .current_limit_active(cla));
  // ------------------------------------------------------------
  // Monitor
  // ------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] s);
    logic [31:0] e;
    e = exp_q.pop_front();
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge clock) begin
    if (rst_n && rd && !wreq) cmp("readdata", rdata);
    if (probe) cmp("observed", {8'h0, scnt, tcnt, 5'h0, pme, hso, lso});
  end
  always @(posedge clock) begin
    if (cnt_clr) begin
      tcnt <= 8'h0;
      scnt <= 8'h0;
    end else begin
      tcnt <= tcnt + 8'(trg);
      scnt <= scnt + 8'(strg);
    end
  end
  // ------------------------------------------------------------
  // Driver tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    // Only the watchdog ends a wait that never gets its answer.
    do begin
      @(posedge clock);
    end while (wreq !== 1'b0);
    wr <= 0;
    rd <= 0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 0);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clock); {cs, pe, se} <= v;
    @(posedge clock); {cs, pe, se} <= 3'h0;
  endtask
  task automatic note(input logic [7:0] t, s, input logic [1:0] p);
    repeat (3) @(posedge clock);
    // Every note follows en, so the module enable is expected high.
    exp_q.push_back({8'h0, s, t, 5'h0, 1'b1, p});
    probe <= 1;
    @(posedge clock); probe <= 0;
  endtask
  task automatic en(input logic [15:0] t);
    bus(1, 4'hc, 0);
    bus(1, 4'h0, {16'h0, t});
    bus(1, 4'hc, 32'h8000);
    @(posedge clock); cnt_clr <= 1;
    @(posedge clock); cnt_clr <= 0;
    repeat (2) @(posedge clock);
  endtask
  task automatic pin_case(input logic [15:0] io, fcl,
                          input logic [2:0] v, input logic [1:0] p);
    bus(1, 4'h4, {16'h0, io}); bus(1, 4'h8, {16'h0, fcl});
    @(posedge clock); {trip, hin, lin} <= v;
    repeat (2) @(posedge clock);
    note(0, 0, p);
  endtask
  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) rd_chk(4'(4 * i), 0);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      bus(1, 4'(4 * i), r);
      rd_chk(4'(4 * i), {16'h0, r[15:0] & mk[i]});
      bus(1, 4'(4 * i), 0);
    end
    bus(1, 4'h6, r); rd_chk(4'h6, 0);
    // Postscale, then drop a partial count across a disable.
    foreach (dv[i]) begin
      en(16'(dv[i] << 12));
      repeat (3 * dv[i] + 2) pulse(3'b010);
      note(2, 0, 0);
      en(16'(dv[i] << 12));
      repeat (dv[i] + 1) pulse(3'b010);
      note(1, 0, 0);
    end
    en(16'h1080);
    repeat (2) begin pulse(3'b010); pulse(3'b001); end
    note(2, 0, 0);
    en(16'h0000);
    repeat (2) pulse(3'b001);
    note(0, 2, 0);
    foreach (dl[i]) begin
      en(16'(dl[i]));
      pulse(3'b010);
      repeat (dl[i] - 1) begin pulse(3'b100); pulse(3'b010); end
      note(0, 0, 0);
      pulse(3'b100); pulse(3'b010);
      note(1, 0, 0);
    end
    en(16'h0000);
    pin_case(16'h0000, 16'h0000, 3'b010, 2'b10);
    pin_case(16'h0002, 16'h0000, 3'b010, 2'b01);
    pin_case(16'h2000, 16'h0000, 3'b010, 2'b00);
    pin_case(16'h1000, 16'h0000, 3'b010, 2'b11);
    pin_case(16'h0008, 16'h0100, 3'b101, 2'b10);
    pin_case(16'h0004, 16'h0100, 3'b110, 2'b01);
    pin_case(16'h2008, 16'h0100, 3'b101, 2'b00);
    pin_case(16'h0008, 16'h8100, 3'b101, 2'b01);
    pin_case(16'h0281, 16'h0000, 3'b000, 2'b00);
    pulse(3'b100);
    note(0, 0, 2'b10);
    pin_case(16'h0200, 16'h0000, 3'b000, 2'b00);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize();
  end
endmodule // tb_top
bind ptoc_top ptoc_assertions chk_u (
  .clock                   (clock),
  .rst_n                   (rst_n),
  .avs_read                (avs_read),
  .avs_write               (avs_write),
  .avs_waitrequest         (avs_waitrequest),
  .pwm_cycle_start         (pwm_cycle_start),
  .primary_trigger_event   (primary_trigger_event),
  .secondary_trigger_event (secondary_trigger_event),
  .pwm_high_in             (pwm_high_in),
  .pwm_low_in              (pwm_low_in),
  .current_limit_active    (current_limit_active),
  .trigger_out             (trigger_out),
  .secondary_trigger_out   (secondary_trigger_out),
  .high_side_output        (high_side_output),
  .low_side_output         (low_side_output),
  .pwm_module_enable       (pwm_module_enable)
);
`default_nettype wire
